// >>> include/toc_pkg.sv
// Constants, field layouts and modes of the timer output-compare block.
// Assumes byte-wide registers that sit in the low lane of a Wishbone word.
package toc_pkg;
  // Reset and reload values
  localparam logic [15:0] CMP_RST = 16'h8000;
  localparam logic [15:0] CNT_RST = 16'hFFFC;
  localparam logic [15:0] CAP_PULSE = 16'hFFFD;
  localparam logic [15:0] CNT_STEP = 16'h0001;

  // Byte addresses of the registers
  localparam logic [5:0] OFF_CTRL1 = 6'h00;
  localparam logic [5:0] OFF_CTRL2 = 6'h04;
  localparam logic [5:0] OFF_STATUS = 6'h08;
  localparam logic [5:0] OFF_CMP1_HI = 6'h0C;
  localparam logic [5:0] OFF_CMP1_LO = 6'h10;
  localparam logic [5:0] OFF_CMP2_HI = 6'h14;
  localparam logic [5:0] OFF_CMP2_LO = 6'h18;
  localparam logic [5:0] OFF_CAP1_HI = 6'h1C;
  localparam logic [5:0] OFF_CAP1_LO = 6'h20;
  localparam logic [5:0] OFF_CAP2_HI = 6'h24;
  localparam logic [5:0] OFF_CAP2_LO = 6'h28;
  localparam logic [5:0] OFF_CNT_HI = 6'h2C;
  localparam logic [5:0] OFF_CNT_LO = 6'h30;

  // Timer clock select codes and prescaler masks
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [2:0] MASK_DIV2 = 3'h1;
  localparam logic [2:0] MASK_DIV4 = 3'h3;
  localparam logic [2:0] MASK_DIV8 = 3'h7;

  typedef enum logic [2:0] {
    TOC_NORMAL = 3'h1,
    TOC_PULSE = 3'h2,
    TOC_PWM = 3'h4
  } toc_mode_e;

  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic spare;
    logic [1:0] forced_level_trigger;
    logic capture_edge_select;
    logic [1:0] compare_output_level;
  } toc_ctrl1_s;

  typedef struct packed {
    logic spare;
    logic capture_edge_two;
    logic one_pulse_select;
    logic pwm_select;
    logic [1:0] timer_clock_select;
    logic [1:0] compare_pin_enable;
  } toc_ctrl2_s;

  typedef struct packed {
    logic capture_one_flag;
    logic compare_one_flag;
    logic spare_hi;
    logic capture_two_flag;
    logic compare_two_flag;
    logic [2:0] spare_lo;
  } toc_status_s;

  // Prescaler mask for the internal divider
  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      CLK_DIV2: div_mask = MASK_DIV2;
      CLK_DIV8: div_mask = MASK_DIV8;
      default: div_mask = MASK_DIV4;
    endcase
  endfunction
endpackage

// >>> core/toc_timer_compare.sv
// Output-compare, one-pulse and PWM part of a 16-bit timer, Wishbone slave.
// Assumes a CPU-side mask input on clk_i; pins and external clock are async.
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Match sets channel flag, drives enabled pin level, requests interrupt if enabled, unmasked.
// - Reset loads both 16-bit compare registers with 8000h.
// - Compare registers are software read/write; hardware never alters them.
// - Two 16-bit compare registers, high/low bytes, compared every timer clock.
// - Timer clock is CPU clock /2, /4, /8 or external by select.
// - Flag clears only after status read while set, then low byte access.
// - Writing high compare byte suppresses matches until low byte is written.
// - Disabled pin gets no level on match; interrupt still possible. Pin one latch ignores its enable in one-pulse and PWM mode.
// - At /2 match while counter equals value; otherwise at value plus one.
// - Compare pin latches held low during reset.
// - Forced-level bit copies level to enabled pin; no flag, no interrupt.
// - Forced-level bits ignored in one-pulse or PWM mode.
// - One-pulse mode bit in control two; capture one triggers, compare one ends.
// - Pulse trigger reloads FFFCh, drives level two, sets capture flag, loads FFFDh.
// - Trigger capture flag requests interrupt when capture interrupt enabled.
// - In one-pulse mode compare one match drives level one, ending pulse.
// - One-pulse mode never sets compare flag one; flag two still interrupts.
// - PWM and one-pulse both set means PWM mode only.
// - One-pulse mode: no ordinary capture one; capture two still works.
// - One-pulse mode: compare two sets flag but drives no waveform.
// - PWM takes compare channel one and compare register two entirely.
// - PWM double-buffers compare registers, applying them at period end.
// - Compares run against a 16-bit free-running up-counter of two bytes.
// - Both clock select bits set choose the external timer clock.
module toc_timer_compare #(
  parameter int DATA_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [DATA_W/8-1:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic global_mask_i,
  input wire logic ext_clk_i,
  input wire logic capture_input_one_i,
  input wire logic capture_input_two_i,
  output logic [1:0] compare_output_pin_o,
  output logic [1:0] compare_pin_enable_o,
  output logic irq_o
);
  if (DATA_W < 8 || DATA_W % 8 != 0) begin : g_bad_width
    $error("DATA_W must be a multiple of 8 and at least 8");
  end

  toc_pkg::toc_ctrl1_s ctrl1;
  toc_pkg::toc_ctrl2_s ctrl2;
  toc_pkg::toc_mode_e mode;
  logic [15:0] cmp_sw [2];
  logic [15:0] cmp_act [2];
  logic [15:0] cap_val [2];
  logic [15:0] cnt;
  logic [2:0] div;
  logic [1:0] hi_pend, cmp_flag, cap_flag, cmp_arm, cap_arm, pin;
  logic ack, upd;
  logic ext_s1, ext_s2, ext_d;
  logic c1_s1, c1_s2, c1_d, c2_s1, c2_s2, c2_d;

  // Bus decode; an access takes effect at the edge that samples ack high
  wire req = wb_cyc_i & wb_stb_i;
  wire acc = req & ack;
  wire wr = acc & wb_we_i & wb_sel_i[0];
  wire rd = acc & ~wb_we_i;
  wire [7:0] wd = wb_dat_i[7:0];
  wire s_c1 = wb_adr_i == toc_pkg::OFF_CTRL1;
  wire s_c2 = wb_adr_i == toc_pkg::OFF_CTRL2;
  wire s_st = wb_adr_i == toc_pkg::OFF_STATUS;
  wire s_o1h = wb_adr_i == toc_pkg::OFF_CMP1_HI;
  wire s_o1l = wb_adr_i == toc_pkg::OFF_CMP1_LO;
  wire s_o2h = wb_adr_i == toc_pkg::OFF_CMP2_HI;
  wire s_o2l = wb_adr_i == toc_pkg::OFF_CMP2_LO;
  wire s_i1h = wb_adr_i == toc_pkg::OFF_CAP1_HI;
  wire s_i1l = wb_adr_i == toc_pkg::OFF_CAP1_LO;
  wire s_i2h = wb_adr_i == toc_pkg::OFF_CAP2_HI;
  wire s_i2l = wb_adr_i == toc_pkg::OFF_CAP2_LO;
  wire s_th = wb_adr_i == toc_pkg::OFF_CNT_HI;
  wire s_tl = wb_adr_i == toc_pkg::OFF_CNT_LO;
  wire [1:0] wr_hi = {wr & s_o2h, wr & s_o1h};
  wire [1:0] wr_lo = {wr & s_o2l, wr & s_o1l};
  wire [1:0] acc_lo = {acc & s_o2l, acc & s_o1l};
  wire [1:0] cap_lo = {acc & s_i2l, acc & s_i1l};
  wire st_rd = rd & s_st;

  // Mode: PWM wins over one-pulse
  assign mode = ctrl2.pwm_select ? toc_pkg::TOC_PWM :
    ctrl2.one_pulse_select ? toc_pkg::TOC_PULSE : toc_pkg::TOC_NORMAL;
  wire m_norm = mode == toc_pkg::TOC_NORMAL;
  wire m_pulse = mode == toc_pkg::TOC_PULSE;
  wire m_pwm = mode == toc_pkg::TOC_PWM;

  // Timer clock: divider mask or synchronised external rising edge
  wire sel_ext = ctrl2.timer_clock_select == toc_pkg::CLK_EXT;
  wire sel_div2 = ctrl2.timer_clock_select == toc_pkg::CLK_DIV2;
  wire [2:0] dmask = toc_pkg::div_mask(ctrl2.timer_clock_select);
  wire tick = sel_ext ? (ext_s2 & ~ext_d) : ((div & dmask) == dmask);

  // Capture edges after two-flop synchronisers
  wire c1_edge = ctrl1.capture_edge_select ? (c1_s2 & ~c1_d) : (~c1_s2 & c1_d);
  wire c2_edge = ctrl2.capture_edge_two ? (c2_s2 & ~c2_d) : (~c2_s2 & c2_d);
  wire trig = m_pulse & c1_edge;
  wire cap1_ev = m_norm & c1_edge;

  // Match detection; fires once on the cycle after the counter moved
  logic [1:0] fire;
  for (genvar i = 0; i < 2; i++) begin : g_ch
    wire [15:0] target = sel_div2 ? cmp_act[i] : cmp_act[i] + toc_pkg::CNT_STEP;
    assign fire[i] = upd & (cnt == target) & ~hi_pend[i];
  end
  wire reload = trig | (m_pwm & fire[1]);

  // Flag set terms; set wins over clear
  wire [1:0] cmp_set = {fire[1] & ~m_pwm, fire[0] & m_norm};
  wire [1:0] cap_set = {c2_edge, cap1_ev | trig | (m_pwm & fire[1])};
  wire [1:0] cmp_clr = cmp_arm & acc_lo;
  wire [1:0] cap_clr = cap_arm & cap_lo;
  wire [1:0] next_cmp_flag = cmp_set | (cmp_flag & ~cmp_clr);
  wire [1:0] next_cap_flag = cap_set | (cap_flag & ~cap_clr);

  // Forced output only in normal mode, and never sets a flag
  wire [1:0] force_ev = (wr & s_c1 & m_norm) ? wd[4:3] : 2'h0;
  // Forced level comes from the byte being written, so one write sets and applies it
  wire [1:0] force_lvl = wd[1:0];
  wire [1:0] lvl = ctrl1.compare_output_level;
  wire [1:0] pen = ctrl2.compare_pin_enable;

  // Pin one: trigger and period end take level two, match one takes level one
  wire [1:0] next_pin;
  assign next_pin[0] = (trig | (m_pwm & fire[1])) ? lvl[1] :
    (fire[0] & (pen[0] | ~m_norm)) ? lvl[0] :
    (force_ev[0] & pen[0]) ? force_lvl[0] : pin[0];
  // Pin two only moves in normal mode, its level is borrowed otherwise
  assign next_pin[1] = (fire[1] & pen[1] & m_norm) ? lvl[1] :
    (force_ev[1] & pen[1]) ? force_lvl[1] : pin[1];

  toc_pkg::toc_status_s stat;
  assign stat = '{capture_one_flag: cap_flag[0], compare_one_flag: cmp_flag[0],
    spare_hi: 1'b0, capture_two_flag: cap_flag[1], compare_two_flag: cmp_flag[1],
    spare_lo: 3'h0};

  // Read selection; forced bits read as zero, unmapped reads as zero
  wire [7:0] rmux = s_c1 ? {ctrl1[7:5], 2'h0, ctrl1[2:0]} : s_c2 ? ctrl2 :
    s_st ? stat : s_o1h ? cmp_sw[0][15:8] : s_o1l ? cmp_sw[0][7:0] :
    s_o2h ? cmp_sw[1][15:8] : s_o2l ? cmp_sw[1][7:0] :
    s_i1h ? cap_val[0][15:8] : s_i1l ? cap_val[0][7:0] :
    s_i2h ? cap_val[1][15:8] : s_i2l ? cap_val[1][7:0] :
    s_th ? cnt[15:8] : s_tl ? cnt[7:0] : 8'h00;

  wire irq_src = (ctrl1.compare_irq_enable & |cmp_flag) |
    (ctrl1.capture_irq_enable & |cap_flag);

  // Bus handshake: ack one cycle after the request, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      ack <= req & ~ack;
      if (req & ~ack) begin
        wb_dat_o <= {{(DATA_W-8){1'b0}}, rmux};
      end
    end
  end
  assign wb_ack_o = ack;

  // Synchronisers for the asynchronous pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {ext_s1, ext_s2, ext_d} <= 3'h0;
      {c1_s1, c1_s2, c1_d} <= 3'h0;
      {c2_s1, c2_s2, c2_d} <= 3'h0;
    end else if (ce_i) begin
      {ext_s1, ext_s2, ext_d} <= {ext_clk_i, ext_s1, ext_s2};
      {c1_s1, c1_s2, c1_d} <= {capture_input_one_i, c1_s1, c1_s2};
      {c2_s1, c2_s2, c2_d} <= {capture_input_two_i, c2_s1, c2_s2};
    end
  end

  // Control registers; forced bits act as strobes and are not kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1 <= '0;
      ctrl2 <= '0;
    end else if (ce_i) begin
      if (wr & s_c1) ctrl1 <= {wd[7:5], 2'h0, wd[2:0]};
      if (wr & s_c2) ctrl2 <= wd;
    end
  end

  // Prescaler and counter; a write of the low count byte restarts it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= 3'h0;
      cnt <= toc_pkg::CNT_RST;
      upd <= 1'b0;
    end else if (ce_i) begin
      div <= div + 3'h1;
      upd <= tick | reload | (wr & s_tl);
      if (reload | (wr & s_tl)) begin
        cnt <= toc_pkg::CNT_RST;
      end else if (tick) begin
        cnt <= cnt + toc_pkg::CNT_STEP;
      end
    end
  end

  // Compare registers, active copies and the high-byte inhibit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 2; i++) begin
        cmp_sw[i] <= toc_pkg::CMP_RST;
        cmp_act[i] <= toc_pkg::CMP_RST;
      end
      hi_pend <= 2'h0;
    end else if (ce_i) begin
      for (int i = 0; i < 2; i++) begin
        if (wr_hi[i]) cmp_sw[i][15:8] <= wd;
        if (wr_lo[i]) cmp_sw[i][7:0] <= wd;
        // In PWM the new value waits for the period end to avoid spikes
        if (~m_pwm | fire[1]) cmp_act[i] <= cmp_sw[i];
        if (wr_hi[i]) hi_pend[i] <= 1'b1;
        else if (wr_lo[i]) hi_pend[i] <= 1'b0;
      end
    end
  end

  // Flags, clear arming and captured values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_flag <= 2'h0;
      cap_flag <= 2'h0;
      cmp_arm <= 2'h0;
      cap_arm <= 2'h0;
      cap_val[0] <= '0;
      cap_val[1] <= '0;
    end else if (ce_i) begin
      cmp_flag <= next_cmp_flag;
      cap_flag <= next_cap_flag;
      cmp_arm <= (st_rd ? cmp_flag : 2'h0) | (cmp_arm & ~acc_lo);
      cap_arm <= (st_rd ? cap_flag : 2'h0) | (cap_arm & ~cap_lo);
      if (trig) cap_val[0] <= toc_pkg::CAP_PULSE;
      else if (cap1_ev) cap_val[0] <= cnt;
      if (c2_edge) cap_val[1] <= cnt;
    end
  end

  // Pin latches and the interrupt line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin <= 2'h0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      pin <= next_pin;
      irq_o <= irq_src & ~global_mask_i;
    end
  end
  assign compare_output_pin_o = pin;
  assign compare_pin_enable_o = pen;

  a_match_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && m_norm && fire[0]) |=> cmp_flag[0])
    else $error("compare one match did not set its flag");
  a_reset_compare: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (cmp_sw[0] == toc_pkg::CMP_RST && cmp_sw[1] == toc_pkg::CMP_RST))
    else $error("compare registers not at reset value");
  a_sw_value_held: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_hi[0] || wr_lo[0]) |=> $stable(cmp_sw[0]))
    else $error("compare one changed without a write");
  a_high_inhibit: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_hi[1]) |=> (!fire[1])[*3])
    else $error("compare two matched while high byte pending");
  a_flag_clear_seq: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && $fell(cmp_flag[0])) |-> $past(cmp_arm[0] && acc_lo[0]))
    else $error("compare one flag cleared without the sequence");
  a_pin_reset_low: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> compare_output_pin_o == 2'h0)
    else $error("compare pins not low after reset");
  a_pulse_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && trig) |=> (cnt == toc_pkg::CNT_RST && pin[0] == $past(lvl[1])
      && cap_val[0] == toc_pkg::CAP_PULSE && cap_flag[0]))
    else $error("pulse trigger effects missing");
  a_pulse_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (m_pulse && !cmp_flag[0]) |=> !cmp_flag[0])
    else $error("compare one flag set in one-pulse mode");
  a_forced_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && force_ev[0] && pen[0] && !fire[0] && !cmp_flag[0])
      |=> (pin[0] == lvl[0] && !cmp_flag[0]))
    else $error("forced level wrong or flag set");
  a_pwm_buffer: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && m_pwm && !fire[1]) |=> $stable(cmp_act[0]) && $stable(cmp_act[1]))
    else $error("PWM compare value applied before period end");
  a_mask_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && global_mask_i) |=> !irq_o)
    else $error("interrupt raised while masked");
endmodule // toc_timer_compare
`default_nettype wire

// >>> tb/toc_timer_compare_bench.sv
// Self-checking bench for the timer output-compare block.
// Assumes the block sits alone; the bench drives Wishbone, pins and clocks.
`timescale 1ns/1ps
`default_nettype none
module toc_timer_compare_bench;
  logic clk_i, rst_i, ce_i, wb_cyc, wb_stb, wb_we, mask, ext_clk, cap1, cap2, irq, wb_ack;
  logic [5:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [1:0] pins, pen, en;
  logic [7:0] exp_q[$];
  logic [7:0] v1, v2;
  logic lv;
  int failures, tests_run;

  toc_timer_compare toc_timer_compare_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .global_mask_i(mask), .ext_clk_i(ext_clk), .capture_input_one_i(cap1),
    .capture_input_two_i(cap2), .compare_output_pin_o(pins),
    .compare_pin_enable_o(pen), .irq_o(irq));

  // Clock at 25 MHz
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // External timer clock, six cycles a period so edges stay well apart
  always begin
    repeat (3) @(posedge clk_i);
    ext_clk <= ~ext_clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One classic cycle; held until ack is sampled, then released
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 8'h00);
  endtask

  task automatic wait_pin(input int idx, input logic val);
    int n;
    n = 0;
    while (pins[idx] !== val && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000) begin
      failures++;
      end_sim();
    end
  endtask

  // Read watcher: oldest note against the data seen at the ack edge
  always @(posedge clk_i) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0) begin
      if (exp_q.size() == 0) begin
        check("read queue", 16'h0001, 16'h0000);
      end else begin
        check("read data", {8'h00, wb_dat_r[7:0]}, {8'h00, exp_q.pop_front()});
      end
    end
  end

  initial begin
    {ce_i, wb_cyc, wb_stb, wb_we, mask, ext_clk, cap1, cap2} = 8'h80;
    rst_i = 1'b1;
    wb_adr = 6'h00;
    wb_sel = 4'hF;
    wb_dat_w = 32'h00000000;
    failures = 0;
    tests_run = 0;
    void'($urandom(38967));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("pins", {14'h0000, pins}, 16'h0000);
    check("irq", {15'h0000, irq}, 16'h0000);
    rd(toc_pkg::OFF_CMP1_HI, 8'h80);
    rd(toc_pkg::OFF_CMP1_LO, 8'h00);
    rd(toc_pkg::OFF_CMP2_HI, 8'h80);
    rd(toc_pkg::OFF_CMP2_LO, 8'h00);
    rd(toc_pkg::OFF_STATUS, 8'h00);
    rd(6'h34, 8'h00);
    rd(6'h02, 8'h00);
    v1 = 8'($urandom());
    wr(toc_pkg::OFF_CMP2_HI, v1);
    rd(toc_pkg::OFF_CMP2_HI, v1);
    $display("test reset and access done");
    // Every clock select: force, match and flag clearing; masking only on the odd clock selects
    for (int cs = 0; cs < 4; cs++) begin
      lv = ~cs[0];
      v2 = 8'h10 + 8'($urandom_range(15));
      v1 = 8'h20 + 8'($urandom_range(15));
      wr(toc_pkg::OFF_CTRL2, {4'h0, 2'(cs), 2'b11});
      wr(toc_pkg::OFF_CTRL1, {6'b000110, ~lv, ~lv});
      rd(toc_pkg::OFF_STATUS, 8'h00);
      check("forced pins", {14'h0000, pins}, {14'h0000, ~lv, ~lv});
      en = (cs == 3) ? 2'b01 : 2'b11;
      wr(toc_pkg::OFF_CTRL2, {4'h0, 2'(cs), en});
      mask <= cs[0];
      wr(toc_pkg::OFF_CMP1_HI, 8'h00);
      wr(toc_pkg::OFF_CMP1_LO, v1);
      wr(toc_pkg::OFF_CMP2_HI, 8'h00);
      wr(toc_pkg::OFF_CMP2_LO, v2);
      wr(toc_pkg::OFF_CTRL1, {6'b010000, lv, lv});
      wr(toc_pkg::OFF_CNT_LO, 8'h00);
      wait_pin(0, lv);
      repeat (2) @(posedge clk_i);
      check("pin two", {15'h0000, pins[1]}, {15'h0000, en[1] ? lv : ~lv});
      check("pin enable", {14'h0000, pen}, {14'h0000, en});
      rd(toc_pkg::OFF_CMP2_LO, v2);
      rd(toc_pkg::OFF_STATUS, 8'h48);
      check("masked irq", {15'h0000, irq}, {15'h0000, ~cs[0]});
      mask <= 1'b0;
      repeat (3) @(posedge clk_i);
      check("unmasked irq", {15'h0000, irq}, 16'h0001);
      rd(toc_pkg::OFF_CMP1_HI, 8'h00);
      rd(toc_pkg::OFF_CMP1_LO, v1);
      rd(toc_pkg::OFF_CMP2_LO, v2);
      rd(toc_pkg::OFF_STATUS, 8'h00);
      repeat (3) @(posedge clk_i);
      check("cleared irq", {15'h0000, irq}, 16'h0000);
      $display("test clock select %0d done", cs);
    end
    // One pulse: trigger on capture one, end on compare one
    wr(toc_pkg::OFF_CTRL2, 8'h25);
    wr(toc_pkg::OFF_CMP1_HI, 8'h00);
    wr(toc_pkg::OFF_CMP1_LO, 8'h40);
    wr(toc_pkg::OFF_CTRL1, 8'h86);
    @(posedge clk_i);
    cap1 <= 1'b1;
    wait_pin(0, 1'b1);
    repeat (2) @(posedge clk_i);
    check("capture irq", {15'h0000, irq}, 16'h0001);
    rd(toc_pkg::OFF_STATUS, 8'h80);
    rd(toc_pkg::OFF_CAP1_HI, 8'hFF);
    rd(toc_pkg::OFF_CAP1_LO, 8'hFD);
    wait_pin(0, 1'b0);
    rd(toc_pkg::OFF_STATUS, 8'h08);
    check("pulse pin two", {15'h0000, pins[1]}, 16'h0001);
    $display("test one pulse done");
    // Both mode bits: period end at compare two sets level two and capture flag
    wr(toc_pkg::OFF_CTRL2, 8'h35);
    wr(toc_pkg::OFF_CNT_LO, 8'h00);
    wait_pin(0, 1'b1);
    repeat (2) @(posedge clk_i);
    rd(toc_pkg::OFF_STATUS, 8'h88);
    $display("test pwm priority done");
    end_sim();
  end
endmodule // toc_timer_compare_bench
`default_nettype wire
